// ==== rtl/dls_pkg.sv ====
package dls_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [11:0] DLS_ADDR_FUSE    = 12'h000;
  localparam logic [11:0] DLS_ADDR_PARAM   = 12'h004;
  localparam logic [11:0] DLS_ADDR_LINK    = 12'h008;
  localparam logic [11:0] DLS_ADDR_SYNC    = 12'h00c;
  localparam logic [11:0] DLS_ADDR_ENABLE  = 12'h010;
  localparam logic [11:0] DLS_ADDR_STATUS  = 12'h014;
  localparam logic [11:0] DLS_ADDR_LANES   = 12'h018;
  localparam logic [11:0] DLS_ADDR_AMP     = 12'h01c;
  localparam logic [11:0] DLS_ADDR_TONE_FREQUENCY    = 12'h020;
  localparam logic [11:0] DLS_ADDR_PHASE   = 12'h024;
  localparam logic [11:0] DLS_ADDR_AMP_R   = 12'h028;
  localparam logic [11:0] DLS_ADDR_TONE_FREQUENCY_R  = 12'h02c;
  localparam logic [11:0] DLS_ADDR_PHASE_R = 12'h030;
  localparam logic [11:0] DLS_ADDR_RESYNC  = 12'h034;
  localparam logic [11:0] DLS_ADDR_LATENCY = 12'h038;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int DLS_ENA_LINK_BIT   = 0;
  localparam int DLS_ENA_PATH_BIT   = 1;
  localparam int DLS_ENA_TONE_BIT   = 2;
  localparam int DLS_SYNC_SLEEP_BIT = 0;
  localparam int DLS_SYNC_PROC_BIT  = 1;
  localparam int DLS_SYNC_ALIGN_BIT = 2;
  localparam int DLS_STAT_UP_BIT    = 0;
  localparam int DLS_STAT_LOCK_BIT  = 1;
  localparam int DLS_STAT_ALGN_BIT  = 2;

  // ---------------------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  DLS_RST_INTERP       = 8'h01;
  localparam logic [3:0]  DLS_RST_STREAMS      = 4'h2;
  localparam logic [7:0]  DLS_RST_KM1          = 8'h1f;
  localparam logic [2:0]  DLS_RST_WAVE         = 3'h0;
  localparam logic        DLS_RST_SYNC_SLEEP   = 1'b1;
  localparam int          DLS_FUSE_CYCLES      = 64;
  localparam int          DLS_DES_EXTRA_LAT    = 97;
  localparam logic [31:0] DLS_UNMAPPED_DATA    = 32'h0000_0000;

  typedef enum logic [2:0] {
    DLS_WAVE_NRZ      = 3'b000,
    DLS_WAVE_RTZ      = 3'b001,
    DLS_WAVE_RF       = 3'b010,
    DLS_WAVE_DES_1X   = 3'b011,
    DLS_WAVE_DES_LOW  = 3'b100,
    DLS_WAVE_DES_HIGH = 3'b101
  } dls_wave_t;

  typedef enum logic [0:0] {
    DLS_ENC_8B10B  = 1'b0,
    DLS_ENC_64B66B = 1'b1
  } dls_enc_t;

  typedef struct packed {
    logic [15:0] tone_amplitude;
    logic [31:0] tone_frequency;
    logic [15:0] phase;
  } dls_tone_t;

  typedef struct packed {
    logic        link_up;
    logic        pll_locked;
    logic        aligned;
    logic [15:0] lane_sync;
  } dls_link_stat_t;

endpackage

// ==== rtl/dls_fuse_loader.sv ====
`timescale 1ns/1ps
module dls_fuse_loader
  import dls_pkg::*;
#(
  parameter int CYCLES = DLS_FUSE_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  output logic      o_done
);

  typedef struct packed {
    logic [15:0] count;
    logic        done;
  } dls_fuse_state_t;

  dls_fuse_state_t state_reg;
  dls_fuse_state_t state_next;

  // ---------------------------------------------------------------------------
  // Fuse load timer
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (!state_reg.done) begin
      if (state_reg.count == 16'(CYCLES - 1)) begin
        state_next.done = 1'b1;
      end else begin
        state_next.count = state_reg.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_done = state_reg.done;

endmodule // dls_fuse_loader

// ==== rtl/dls_des_delay.sv ====
`timescale 1ns/1ps
module dls_des_delay
  import dls_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = DLS_DES_EXTRA_LAT
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_data,
  output logic      [WIDTH-1:0] o_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] pipe;
  } dls_delay_state_t;

  dls_delay_state_t state_reg;
  dls_delay_state_t state_next;

  // ---------------------------------------------------------------------------
  // Fixed latency line
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.pipe[0] = i_data;
    for (int i = 1; i < DEPTH; i++) begin
      state_next.pipe[i] = state_reg.pipe[i-1];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_data = state_reg.pipe[DEPTH-1];

endmodule // dls_des_delay

// ==== rtl/dls_sequencer.sv ====
`timescale 1ns/1ps
module dls_sequencer
  import dls_pkg::*;
#(
  parameter int LANES       = 16,
  parameter int SAMPLE_W    = 16,
  parameter int FUSE_CYCLES = DLS_FUSE_CYCLES
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rstn,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [11:0]           i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  input  wire logic                  i_serdes_pll_locked,
  input  wire logic                  i_link_established,
  input  wire logic                  i_syncref_aligned,
  input  wire logic [LANES-1:0]      i_lane_sync,
  input  wire logic [2*SAMPLE_W-1:0] i_link_samples,
  input  wire logic [2*SAMPLE_W-1:0] i_interp_samples,
  output logic                       o_link_receiver_on,
  output dls_enc_t                   o_link_encoding_select,
  output logic      [7:0]            o_frames_per_multiframe_m1,
  output logic      [7:0]            o_rx_buffer_delay,
  output logic      [7:0]            o_link_mode_select,
  output logic                       o_syncref_receiver_sleep,
  output logic                       o_syncref_processing_on,
  output logic                       o_syncref_alignment_on,
  output logic      [3:0]            o_syncref_capture_select,
  output logic      [7:0]            o_upconv_interp_factor,
  output logic      [7:0]            o_total_interp_factor,
  output logic      [3:0]            o_oscillator_on,
  output logic                       o_complex_output_select,
  output logic      [7:0]            o_converter_source_route,
  output dls_wave_t                  o_output_waveform_mode,
  output logic                       o_interp_highpass,
  output logic                       o_interp_active,
  output dls_tone_t                  o_tone_active,
  output logic      [2*SAMPLE_W-1:0] o_converter_samples
);

  typedef struct packed {
    logic [7:0]            interp;
    logic [3:0]            stream_count;
    logic                  complex_sel;
    logic [7:0]            route;
    dls_wave_t             wave;
    dls_enc_t              enc;
    logic [7:0]            km1;
    logic [7:0]            rx_buffer_delay;
    logic [7:0]            lmode;
    logic                  subclass1;
    logic                  sync_sleep;
    logic                  sync_proc;
    logic                  sync_align;
    logic [3:0]            sync_sel;
    logic                  link_on;
    logic                  path_on;
    logic                  tone_on;
    dls_tone_t             tone_wr;
    dls_tone_t             tone_act;
    logic                  resync;
    logic [31:0]           rdata;
    logic [2*SAMPLE_W-1:0] samples;
  } dls_state_t;

  dls_state_t                state_reg;
  dls_state_t                state_next;
  logic                      fuse_done;
  logic [2*SAMPLE_W-1:0]     des_delayed;
  logic                      wr_en;
  logic                      rd_en;
  logic                      mapped;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  function automatic logic dls_is_mapped(input logic [11:0] addr);
    case (addr)
      DLS_ADDR_FUSE, DLS_ADDR_PARAM, DLS_ADDR_LINK, DLS_ADDR_SYNC, DLS_ADDR_ENABLE,
      DLS_ADDR_STATUS, DLS_ADDR_LANES, DLS_ADDR_AMP, DLS_ADDR_TONE_FREQUENCY, DLS_ADDR_PHASE,
      DLS_ADDR_AMP_R, DLS_ADDR_TONE_FREQUENCY_R, DLS_ADDR_PHASE_R, DLS_ADDR_RESYNC,
      DLS_ADDR_LATENCY: dls_is_mapped = 1'b1;
      default:          dls_is_mapped = 1'b0;
    endcase
  endfunction

  // Maps the stream count to a mask of synthesis channels.
  function automatic logic [3:0] dls_chan_mask(input logic [3:0] streams);
    case (streams)
      4'h2:    dls_chan_mask = 4'h1;
      4'h4:    dls_chan_mask = 4'h3;
      4'h6:    dls_chan_mask = 4'h7;
      4'h8:    dls_chan_mask = 4'hf;
      default: dls_chan_mask = 4'h0;
    endcase
  endfunction

  // Interpolating dual-edge modes.
  function automatic logic dls_is_interp(input dls_wave_t w);
    dls_is_interp = (w == DLS_WAVE_DES_LOW) || (w == DLS_WAVE_DES_HIGH);
  endfunction

  assign mapped = dls_is_mapped(i_paddr);
  assign wr_en  = i_psel && i_penable && i_pwrite && mapped && fuse_done;
  assign rd_en  = i_psel && !i_penable && !i_pwrite;

  // ---------------------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------------------
  dls_fuse_loader #(
    .CYCLES (FUSE_CYCLES)
  ) u_fuse (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .o_done (fuse_done)
  );

  dls_des_delay #(
    .WIDTH (2*SAMPLE_W),
    .DEPTH (DLS_DES_EXTRA_LAT)
  ) u_des_delay (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_data (i_interp_samples),
    .o_data (des_delayed)
  );

  // ---------------------------------------------------------------------------
  // Register and sequencing logic
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next        = state_reg;
    state_next.resync = 1'b0;
    if (wr_en) begin
      case (i_paddr)
        DLS_ADDR_PARAM: begin
          state_next.interp       = i_pwdata[7:0];
          state_next.stream_count = i_pwdata[11:8];
          state_next.complex_sel  = i_pwdata[12];
          state_next.wave         = dls_wave_t'(i_pwdata[18:16]);
          state_next.route        = i_pwdata[31:24];
        end
        DLS_ADDR_LINK: begin
          state_next.enc       = dls_enc_t'(i_pwdata[0]);
          state_next.subclass1 = i_pwdata[1];
          state_next.km1       = i_pwdata[15:8];
          state_next.rx_buffer_delay       = i_pwdata[23:16];
          state_next.lmode     = i_pwdata[31:24];
        end
        DLS_ADDR_SYNC: begin
          state_next.sync_sleep = i_pwdata[DLS_SYNC_SLEEP_BIT];
          state_next.sync_proc  = i_pwdata[DLS_SYNC_PROC_BIT];
          state_next.sync_align = i_pwdata[DLS_SYNC_ALIGN_BIT];
          state_next.sync_sel   = i_pwdata[7:4];
        end
        DLS_ADDR_ENABLE: begin
          state_next.link_on = i_pwdata[DLS_ENA_LINK_BIT];
          state_next.path_on = i_pwdata[DLS_ENA_PATH_BIT];
          state_next.tone_on = i_pwdata[DLS_ENA_TONE_BIT];
        end
        DLS_ADDR_AMP:    state_next.tone_wr.tone_amplitude   = i_pwdata[15:0];
        DLS_ADDR_TONE_FREQUENCY:   state_next.tone_wr.tone_frequency  = i_pwdata;
        DLS_ADDR_PHASE:  state_next.tone_wr.phase = i_pwdata[15:0];
        DLS_ADDR_RESYNC: state_next.resync        = i_pwdata[0];
        default: begin
        end
      endcase
    end
    // New tone values reach the oscillators only on a resync strobe.
    if (state_reg.resync) begin
      state_next.tone_act = state_reg.tone_wr;
    end
    if (rd_en) begin
      case (i_paddr)
        DLS_ADDR_FUSE:    state_next.rdata = {31'h0, fuse_done};
        DLS_ADDR_PARAM:   state_next.rdata = {state_reg.route, 5'h0, state_reg.wave, 3'h0,
                                              state_reg.complex_sel, state_reg.stream_count,
                                              state_reg.interp};
        DLS_ADDR_LINK:    state_next.rdata = {state_reg.lmode, state_reg.rx_buffer_delay, state_reg.km1,
                                              6'h0, state_reg.subclass1, state_reg.enc};
        DLS_ADDR_SYNC:    state_next.rdata = {24'h0, state_reg.sync_sel, 1'b0,
                                              state_reg.sync_align, state_reg.sync_proc,
                                              state_reg.sync_sleep};
        DLS_ADDR_ENABLE:  state_next.rdata = {29'h0, state_reg.tone_on, state_reg.path_on,
                                              state_reg.link_on};
        DLS_ADDR_STATUS:  state_next.rdata = {29'h0, i_syncref_aligned, i_serdes_pll_locked,
                                              i_link_established};
        DLS_ADDR_LANES:   state_next.rdata = 32'(i_lane_sync);
        DLS_ADDR_AMP:     state_next.rdata = {16'h0, state_reg.tone_wr.tone_amplitude};
        DLS_ADDR_TONE_FREQUENCY:    state_next.rdata = state_reg.tone_wr.tone_frequency;
        DLS_ADDR_PHASE:   state_next.rdata = {16'h0, state_reg.tone_wr.phase};
        DLS_ADDR_AMP_R:   state_next.rdata = {16'h0, state_reg.tone_act.tone_amplitude};
        DLS_ADDR_TONE_FREQUENCY_R:  state_next.rdata = state_reg.tone_act.tone_frequency;
        DLS_ADDR_PHASE_R: state_next.rdata = {16'h0, state_reg.tone_act.phase};
        DLS_ADDR_LATENCY: state_next.rdata = dls_is_interp(state_reg.wave) ?
                                             32'(DLS_DES_EXTRA_LAT) : 32'h0;
        default:          state_next.rdata = DLS_UNMAPPED_DATA;
      endcase
    end
    // Samples flow only with the path enabled; interpolating modes take the delayed stream.
    if (!state_reg.path_on) begin
      state_next.samples = '0;
    end else if (dls_is_interp(state_reg.wave)) begin
      state_next.samples = des_delayed;
    end else begin
      state_next.samples = i_link_samples;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg              <= '0;
      state_reg.interp       <= DLS_RST_INTERP;
      state_reg.stream_count <= DLS_RST_STREAMS;
      state_reg.km1          <= DLS_RST_KM1;
      state_reg.wave         <= dls_wave_t'(DLS_RST_WAVE);
      state_reg.sync_sleep   <= DLS_RST_SYNC_SLEEP;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign o_prdata                   = state_reg.rdata;
  assign o_pready                   = 1'b1;
  assign o_pslverr                  = i_psel && i_penable && !mapped;
  assign o_link_receiver_on         = state_reg.link_on;
  assign o_link_encoding_select     = state_reg.enc;
  assign o_frames_per_multiframe_m1 = state_reg.km1;
  assign o_rx_buffer_delay          = state_reg.rx_buffer_delay;
  assign o_link_mode_select         = state_reg.lmode;
  assign o_syncref_receiver_sleep   = state_reg.sync_sleep;
  assign o_syncref_processing_on    = state_reg.sync_proc;
  assign o_syncref_alignment_on     = state_reg.sync_align;
  assign o_syncref_capture_select   = state_reg.sync_sel;
  assign o_upconv_interp_factor     = state_reg.interp;
  // Both factors are equal in every mode.
  assign o_total_interp_factor      = state_reg.interp;
  assign o_oscillator_on            = (state_reg.tone_on && state_reg.path_on) ?
                                      dls_chan_mask(state_reg.stream_count) : 4'h0;
  assign o_complex_output_select    = state_reg.complex_sel;
  assign o_converter_source_route   = state_reg.route;
  assign o_output_waveform_mode     = state_reg.wave;
  assign o_interp_highpass          = (state_reg.wave == DLS_WAVE_DES_HIGH);
  assign o_interp_active            = dls_is_interp(state_reg.wave);
  assign o_tone_active              = state_reg.tone_act;
  assign o_converter_samples        = state_reg.samples;

endmodule // dls_sequencer

// ==== tb/dls_seq_checker.sv ====
`timescale 1ns/1ps
module dls_seq_checker
  import dls_pkg::*;
#(
  parameter int FUSE_CYCLES = DLS_FUSE_CYCLES
) (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire dls_enc_t    o_link_encoding_select,
  input wire logic [7:0]  o_frames_per_multiframe_m1,
  input wire logic [7:0]  o_upconv_interp_factor,
  input wire logic [7:0]  o_total_interp_factor,
  input wire logic [3:0]  o_oscillator_on,
  input wire dls_wave_t   o_output_waveform_mode,
  input wire logic        o_interp_highpass,
  input wire logic        o_interp_active,
  input wire dls_tone_t   o_tone_active
);
  // ---------------------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------------------
  // Writes are only checked once the fuse load has surely finished.
  int unsigned up_cnt;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      up_cnt <= 0;
    end else if (up_cnt < FUSE_CYCLES + 3) begin
      up_cnt <= up_cnt + 1;
    end
  end
  wire logic acc   = i_psel && i_penable;
  wire logic open  = up_cnt >= FUSE_CYCLES + 3;
  wire logic rs_wr = acc && i_pwrite && i_paddr == DLS_ADDR_RESYNC && i_pwdata[0] && open;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_wr_link;
    acc && i_pwrite && i_paddr == DLS_ADDR_LINK && open;
  endsequence
  sequence s_rd_amp;
    acc && !i_pwrite && i_paddr == DLS_ADDR_AMP_R;
  endsequence

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  ready_high_a: assert property (o_pready) else $error("pready low");
  unmapped_err_a: assert property (acc && i_paddr[1:0] == 2'b00 |-> o_pslverr == (i_paddr > DLS_ADDR_LATENCY))
    else $error("pslverr wrong");
  unmapped_data_a: assert property (acc && !i_pwrite && i_paddr > DLS_ADDR_LATENCY |-> o_prdata == DLS_UNMAPPED_DATA)
    else $error("unmapped read data nonzero");
  link_write_a: assert property (s_wr_link |=> o_link_encoding_select == $past(i_pwdata[0])
    && o_frames_per_multiframe_m1 == $past(i_pwdata[15:8])) else $error("link write not applied");
  total_interp_a: assert property (o_total_interp_factor == o_upconv_interp_factor) else $error("total interp");
  osc_mask_a: assert property (o_oscillator_on inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf}) else $error("osc mask");
  interp_sel_a: assert property (o_interp_active == (o_output_waveform_mode inside {DLS_WAVE_DES_LOW,
    DLS_WAVE_DES_HIGH})) else $error("interp active wrong");
  highpass_sel_a: assert property (o_interp_active |-> o_interp_highpass == (o_output_waveform_mode ==
    DLS_WAVE_DES_HIGH)) else $error("highpass wrong");
  tone_resync_a: assert property ($changed(o_tone_active) |-> $past(rs_wr, 2) || $past(rs_wr, 3))
    else $error("tone changed without resync");
  amp_readback_a: assert property (s_rd_amp |-> o_prdata[15:0] == o_tone_active.tone_amplitude)
    else $error("amp readback");
endmodule // dls_seq_checker

bind dls_sequencer dls_seq_checker #(.FUSE_CYCLES(FUSE_CYCLES)) i_seq_chk (
  .i_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
  .o_link_encoding_select, .o_frames_per_multiframe_m1, .o_upconv_interp_factor, .o_total_interp_factor,
  .o_oscillator_on, .o_output_waveform_mode, .o_interp_highpass, .o_interp_active, .o_tone_active);

// ==== tb/dls_link_partner.sv ====
`timescale 1ns/1ps
module dls_link_partner
  import dls_pkg::*;
#(
  parameter int LANES      = 16,
  parameter int LINK_DELAY = 8
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_link_receiver_on,
  input  wire logic        i_syncref_sleep,
  input  wire logic        i_syncref_proc,
  input  wire logic        i_syncref_align,
  output logic             o_pll_locked,
  output logic             o_link_up,
  output logic             o_aligned,
  output logic [LANES-1:0] o_lane_sync,
  output logic [31:0]      o_link_samples,
  output logic [31:0]      o_interp_samples
);
  // ---------------------------------------------------------------------------
  // Transmitter and reference source
  // ---------------------------------------------------------------------------
  // The transmitter sends from reset on, so it is always ahead of the enable.
  logic [15:0] cnt;
  int          up_cnt;
  int          pulses;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt    <= 16'h0000;
      up_cnt <= 0;
      pulses <= 0;
    end else begin
      cnt    <= cnt + 16'h0001;
      up_cnt <= i_link_receiver_on ? (up_cnt < LINK_DELAY ? up_cnt + 1 : up_cnt) : 0;
      if (i_syncref_align && i_syncref_proc && !i_syncref_sleep && cnt[3:0] == 4'hf && pulses < 8) begin
        pulses <= pulses + 1;
      end
    end
  end
  assign o_pll_locked     = i_rstn;
  assign o_link_up        = up_cnt >= LINK_DELAY;
  assign o_lane_sync      = o_link_up ? {LANES{1'b1}} : {LANES{1'b0}};
  assign o_aligned        = pulses >= 5;
  assign o_link_samples   = {cnt, cnt ^ 16'ha5a5};
  assign o_interp_samples = {~cnt, cnt};
endmodule // dls_link_partner

// ==== tb/dac_link_startup_sequencer_tb.sv ====
`timescale 1ns/1ps
module dac_link_startup_sequencer_tb
  import dls_pkg::*;
;
  localparam int FUSE = 16;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, lsm, ism;
  logic        pready, pslverr, err, lock, lup, algn;
  logic [15:0] lanes;
  logic        link_on, sleep, proc, align, hp, iact, cplx;
  dls_enc_t    enc;
  dls_wave_t   wave;
  logic [7:0]  km1, rx_buffer_delay, lmode, upc, tot, route;
  logic [3:0]  osc, sel;
  dls_tone_t   tone;
  logic [31:0] conv;
  logic [31:0] hl[128];
  logic [31:0] hi[128];
  logic [6:0]  cyc = 7'h00;
  int          failures = 0;
  int          comparisons = 0;

  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    hl[cyc] <= lsm;
    hi[cyc] <= ism;
    cyc     <= cyc + 7'h01;
  end

  dls_sequencer #(.LANES(16), .SAMPLE_W(16), .FUSE_CYCLES(FUSE)) i_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_serdes_pll_locked(lock),
    .i_link_established(lup), .i_syncref_aligned(algn), .i_lane_sync(lanes), .i_link_samples(lsm),
    .i_interp_samples(ism), .o_link_receiver_on(link_on), .o_link_encoding_select(enc),
    .o_frames_per_multiframe_m1(km1), .o_rx_buffer_delay(rx_buffer_delay), .o_link_mode_select(lmode),
    .o_syncref_receiver_sleep(sleep), .o_syncref_processing_on(proc), .o_syncref_alignment_on(align),
    .o_syncref_capture_select(sel), .o_upconv_interp_factor(upc), .o_total_interp_factor(tot),
    .o_oscillator_on(osc), .o_complex_output_select(cplx), .o_converter_source_route(route),
    .o_output_waveform_mode(wave), .o_interp_highpass(hp), .o_interp_active(iact), .o_tone_active(tone),
    .o_converter_samples(conv));

  dls_link_partner #(.LANES(16), .LINK_DELAY(8)) i_partner (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_link_receiver_on(link_on), .i_syncref_sleep(sleep),
    .i_syncref_proc(proc), .i_syncref_align(align), .o_pll_locked(lock), .o_link_up(lup), .o_aligned(algn),
    .o_lane_sync(lanes), .o_link_samples(lsm), .o_interp_samples(ism));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge i_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    rc("fuse early", DLS_ADDR_FUSE, 32'h0000_0000);
    wr(DLS_ADDR_PARAM, 32'h0000_0404);
    for (int i = 0; i < 40 && rd[0] !== 1'b1; i++) xfer(DLS_ADDR_FUSE, 1'b0, 32'h0000_0000);
    chk("fuse done", 32'h0000_0001, rd);
    rc("param rst", DLS_ADDR_PARAM, 32'h0000_0201);
    rc("link rst", DLS_ADDR_LINK, 32'h0000_1f00);
    rc("sync rst", DLS_ADDR_SYNC, 32'h0000_0001);
    rc("ena rst", DLS_ADDR_ENABLE, 32'h0000_0000);
    rc("unmapped", 12'h03c, DLS_UNMAPPED_DATA);
    chk("unmapped err", 32'h1, err);
    for (int e = 0; e < 2; e++) begin
      wr(DLS_ADDR_LINK, 32'h0710_3c02 | e);
      chk("enc", e, enc);
      chk("km1", 32'h3c, km1);
      chk("rbd", 32'h10, rx_buffer_delay);
      chk("lmode", 32'h07, lmode);
      rc("link rb", DLS_ADDR_LINK, 32'h0710_3c02 | e);
    end
    wr(DLS_ADDR_PARAM, 32'h0000_0204);
    chk("total", 32'h04, tot);
    chk("upconv", 32'h04, upc);
    wr(DLS_ADDR_SYNC, 32'h0000_0000);
    wr(DLS_ADDR_SYNC, 32'h0000_0002);
    wr(DLS_ADDR_SYNC, 32'h0000_0052);
    wr(DLS_ADDR_SYNC, 32'h0000_0056);
    chk("sync", 32'h56, {sel, 1'b0, align, proc, sleep});
    wr(DLS_ADDR_ENABLE, 32'h0000_0001);
    chk("rx on", 32'h1, link_on);
    repeat (2) @(posedge i_clk);
    #1 chk("path off", 32'h0, conv);
    repeat (120) @(posedge i_clk);
    rc("status", DLS_ADDR_STATUS, 32'h0000_0007);
    rc("lanes", DLS_ADDR_LANES, 32'h0000_ffff);
    wr(DLS_ADDR_ENABLE, 32'h0000_0003);
    repeat (3200) @(posedge i_clk);
    for (int m = 0; m < 6; m++) begin
      wr(DLS_ADDR_PARAM, (m << 16) | 32'h0000_0204);
      repeat (110) @(posedge i_clk);
      #1 chk("samples", (m >= 4) ? hi[cyc - 7'd98] : hl[cyc - 7'd1], conv);
      chk("wave", m, wave);
      chk("interp", m >= 4, iact);
      chk("highpass", (m == 5) ? 1 : 0, iact & hp);
      rc("latency", DLS_ADDR_LATENCY, (m >= 4) ? DLS_DES_EXTRA_LAT : 0);
    end
    wr(DLS_ADDR_ENABLE, 32'h0000_0000);
    chk("rx off", 32'h0, link_on);
    wr(DLS_ADDR_ENABLE, 32'h0000_0004);
    chk("osc gated", 32'h0, osc);
    wr(DLS_ADDR_ENABLE, 32'h0000_0006);
    repeat (3200) @(posedge i_clk);
    for (int i = 0; i < 4; i++) begin
      wr(DLS_ADDR_PARAM, ((2 * i + 2) << 8) | 32'h0000_0001);
      chk("osc", (1 << (i + 1)) - 1, osc);
    end
    wr(DLS_ADDR_PARAM, 32'h5a00_1401);
    chk("route", 32'h5a, route);
    chk("complex", 32'h1, cplx);
    chk("osc cplx", 32'h3, osc);
    wr(DLS_ADDR_AMP, 32'h0000_1234);
    wr(DLS_ADDR_TONE_FREQUENCY, 32'hdead_beef);
    rc("amp old", DLS_ADDR_AMP_R, 32'h0000_0000);
    chk("tone old", 32'h0, tone.tone_amplitude);
    wr(DLS_ADDR_RESYNC, 32'h0000_0001);
    repeat (3) @(posedge i_clk);
    rc("amp new", DLS_ADDR_AMP_R, 32'h0000_1234);
    rc("tone_frequency new", DLS_ADDR_TONE_FREQUENCY_R, 32'hdead_beef);
    chk("tone new", 32'hdead_beef, tone.tone_frequency);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    rc("param rst2", DLS_ADDR_PARAM, 32'h0000_0201);
    wrap_up();
  end
endmodule // dac_link_startup_sequencer_tb
